/* File: design/fts_pkg.sv */
package fts_pkg;

  // ------------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DEPTH = 262144;
  localparam int LANE_W = 9;
  localparam int LANES = 2;
  localparam int WORD_W = LANE_W * LANES;
  localparam int BYTE_W = 8;
  localparam int BURST_W = 2;

  // ------------------------------------------------------------------
  // reset values and synchroniser depth
  // ------------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 18'h00000;
  localparam logic [WORD_W-1:0] WORD_RST = 18'h00000;
  // order strap is pulled up, so interleaved until the pin is seen
  localparam logic MODE_RST = 1'h1;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------------
  // access state
  // ------------------------------------------------------------------
  typedef enum logic {
    FTS_DESELECTED,
    FTS_ACTIVE
  } fts_state_type;

  // burst offset from start offset and beat count
  function automatic logic [BURST_W-1:0] seq_offset(
    input logic [BURST_W-1:0] start,
    input logic [BURST_W-1:0] count,
    input logic interleaved
  );
    logic [BURST_W-1:0] res;
    res = interleaved ? (start ^ count) : BURST_W'(start + count);
    return res;
  endfunction

endpackage

/* File: design/fts_burst_ctr.sv */
// ------------------------------------------------------------------
// two-bit burst counter
// ------------------------------------------------------------------
module fts_burst_ctr (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_load,
  input wire logic [fts_pkg::BURST_W-1:0] i_start,
  input wire logic i_step,
  input wire logic i_interleaved,
  output logic [fts_pkg::BURST_W-1:0] o_offset,
  output logic [fts_pkg::BURST_W-1:0] o_offset_nxt
);

  logic [fts_pkg::BURST_W-1:0] start_r;
  logic [fts_pkg::BURST_W-1:0] start_nxt;
  logic [fts_pkg::BURST_W-1:0] count_r;
  logic [fts_pkg::BURST_W-1:0] count_nxt;

  // load seeds start and clears count; step wraps modulo four
  always_comb
  begin
    start_nxt = start_r;
    count_nxt = count_r;
    if (i_load)
    begin
      start_nxt = i_start;
      count_nxt = fts_pkg::BURST_RST;
    end
    else if (i_step)
    begin
      count_nxt = fts_pkg::BURST_W'(count_r + 2'h1);
    end
  end

  // counter state
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      start_r <= fts_pkg::BURST_RST;
      count_r <= fts_pkg::BURST_RST;
    end
    else
    begin
      start_r <= start_nxt;
      count_r <= count_nxt;
    end
  end

  // order is applied on the fly so a change of i_interleaved shows at once
  assign o_offset = fts_pkg::seq_offset(start_r, count_r, i_interleaved);
  assign o_offset_nxt = fts_pkg::seq_offset(start_nxt, count_nxt, i_interleaved);

endmodule

/* File: design/fts_lane_write.sv */
// ------------------------------------------------------------------
// byte lane write enables
// ------------------------------------------------------------------
module fts_lane_write (
  input wire logic i_allow,
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [fts_pkg::LANES-1:0] i_byte_write_select_n,
  output logic [fts_pkg::LANES-1:0] o_lane_we
);

  // global write overrides selects; selects need the enable
  always_comb
  begin
    if (!i_allow)
    begin
      o_lane_we = '0;
    end
    else if (!i_global_write_n)
    begin
      o_lane_we = '1;
    end
    else if (!i_byte_write_enable_n)
    begin
      o_lane_we = ~i_byte_write_select_n;
    end
    else
    begin
      o_lane_we = '0;
    end
  end

endmodule

/* File: design/fts_sram.sv */
module fts_sram (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [fts_pkg::ADDR_W-1:0] i_addr,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_byte_write_select_lane0_n,
  input wire logic i_byte_write_select_lane1_n,
  input wire logic i_byte_write_enable_n,
  input wire logic i_global_write_n,
  input wire logic i_chip_select_one_n,
  input wire logic i_chip_select_two,
  input wire logic i_chip_select_three_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic i_burst_order_strap,
  input wire logic [2*fts_pkg::BYTE_W-1:0] i_data_io,
  input wire logic [fts_pkg::LANES-1:0] i_parity_io,
  output logic [2*fts_pkg::BYTE_W-1:0] o_data_io,
  output logic [fts_pkg::LANES-1:0] o_parity_io,
  output logic o_data_io_oe
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  fts_pkg::fts_state_type state_r;
  fts_pkg::fts_state_type state_nxt;
  logic [fts_pkg::ADDR_W-1:0] addr_r;
  logic [fts_pkg::ADDR_W-1:0] addr_nxt;
  logic [fts_pkg::WORD_W-1:0] mem [fts_pkg::DEPTH];
  logic [fts_pkg::WORD_W-1:0] rd_data_r;
  logic [fts_pkg::WORD_W-1:0] rd_data_nxt;
  logic [fts_pkg::WORD_W-1:0] wr_word;
  logic [fts_pkg::SYNC_STAGES-1:0] strap_sync_r;
  logic interleaved_r;
  logic oe_mask_r;
  logic oe_mask_nxt;
  logic selected;
  logic proc_start;
  logic ctrl_start;
  logic load;
  logic step;
  logic wr_allow;
  logic [fts_pkg::LANES-1:0] lane_we;
  logic [fts_pkg::BURST_W-1:0] offset;
  logic [fts_pkg::BURST_W-1:0] offset_nxt;

  // ------------------------------------------------------------------
  // order strap capture
  // ------------------------------------------------------------------

  // strap comes off a pin, so three flops before it is trusted
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      strap_sync_r <= {fts_pkg::SYNC_STAGES{fts_pkg::MODE_RST}};
    end
    else
    begin
      strap_sync_r <= {strap_sync_r[1:0], i_burst_order_strap};
    end
  end

  // order from strap
  // a change counts only once the last two stages agree
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      interleaved_r <= fts_pkg::MODE_RST;
    end
    else if (strap_sync_r[1] == strap_sync_r[2])
    begin
      interleaved_r <= strap_sync_r[2];
    end
  end

  // ------------------------------------------------------------------
  // strobe and select decode
  // ------------------------------------------------------------------

  assign selected = !i_chip_select_one_n && i_chip_select_two && !i_chip_select_three_n;

  // processor strobe gated by select one
  assign proc_start = !i_processor_addr_strobe_n && !i_chip_select_one_n;

  // controller strobe only when processor strobe not taken
  // either strobe may open a burst
  assign ctrl_start = !i_controller_addr_strobe_n && !proc_start;

  // selects matter only on a load edge
  assign load = proc_start || ctrl_start;

  // advance low steps while active and not loading
  // later beats come from the counter, not the pins
  assign step = !load && (state_r == fts_pkg::FTS_ACTIVE) && !i_burst_advance_n;

  // ------------------------------------------------------------------
  // access state
  // ------------------------------------------------------------------

  // a strobe edge decides selection for the new access
  always_comb
  begin
    state_nxt = state_r;
    if (load)
    begin
      state_nxt = selected ? fts_pkg::FTS_ACTIVE : fts_pkg::FTS_DESELECTED;
    end
  end

  // control state registered on the rising edge
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= fts_pkg::FTS_DESELECTED;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------------
  // address register and burst counter
  // ------------------------------------------------------------------

  // pins used only when strobed and selected
  always_comb
  begin
    addr_nxt = {addr_r[fts_pkg::ADDR_W-1:fts_pkg::BURST_W], offset_nxt};
    if (load && selected)
    begin
      addr_nxt = i_addr;
    end
  end

  // external address held in its register
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      addr_r <= fts_pkg::ADDR_RST;
    end
    else
    begin
      addr_r <= addr_nxt;
    end
  end

  // low two address bits seed the counter
  // offset order worked out in the counter
  fts_burst_ctr u_burst_ctr (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_load(load && selected),
    .i_start(i_addr[fts_pkg::BURST_W-1:0]),
    .i_step(step),
    .i_interleaved(interleaved_r),
    .o_offset(offset),
    .o_offset_nxt(offset_nxt)
  );

  // ------------------------------------------------------------------
  // write path
  // ------------------------------------------------------------------

  // processor strobe edges are always reads; writes follow on later
  // edges or come with the controller strobe
  // sleep blocks writes so stored contents stay put
  // sleep gates writes without passing through a flop
  assign wr_allow = !i_sleep_request && (state_nxt == fts_pkg::FTS_ACTIVE) &&
                    !proc_start;

  fts_lane_write u_lane_write (
    .i_allow(wr_allow),
    .i_global_write_n(i_global_write_n),
    .i_byte_write_enable_n(i_byte_write_enable_n),
    .i_byte_write_select_n({i_byte_write_select_lane1_n, i_byte_write_select_lane0_n}),
    .o_lane_we(lane_we)
  );

  // lane k carries its parity bit above its byte
  assign wr_word = {i_parity_io[1], i_data_io[15:8], i_parity_io[0], i_data_io[7:0]};

  // data taken with controls, at the current beat address
  // array has no reset: contents survive a reset as they would power
  always_ff @(posedge i_sys_clk)
  begin
    for (int k = 0; k < fts_pkg::LANES; k++)
    begin
      if (lane_we[k])
      begin
        mem[addr_nxt][k*fts_pkg::LANE_W +: fts_pkg::LANE_W] <=
          wr_word[k*fts_pkg::LANE_W +: fts_pkg::LANE_W];
      end
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------

  // word at the address taken on this edge, merged with any
  // lane written on the same edge so the output never shows stale data
  always_comb
  begin
    rd_data_nxt = mem[addr_nxt];
    for (int k = 0; k < fts_pkg::LANES; k++)
    begin
      if (lane_we[k])
      begin
        rd_data_nxt[k*fts_pkg::LANE_W +: fts_pkg::LANE_W] =
          wr_word[k*fts_pkg::LANE_W +: fts_pkg::LANE_W];
      end
    end
  end

  // first beat after strobe edge, later beats one per clock with advance low
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rd_data_r <= fts_pkg::WORD_RST;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign o_data_io = {rd_data_r[16:9], rd_data_r[7:0]};
  assign o_parity_io = {rd_data_r[17], rd_data_r[8]};

  // ------------------------------------------------------------------
  // output enable
  // ------------------------------------------------------------------

  // a read that opens from deselect masks drive for one clock
  // this keeps the bus quiet while another device may still turn off
  always_comb
  begin
    oe_mask_nxt = 1'h0;
    if (load && selected && (state_r == fts_pkg::FTS_DESELECTED) && (lane_we == '0))
    begin
      oe_mask_nxt = 1'h1;
    end
  end

  // mask lasts exactly the first clock of that read
  always_ff @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      oe_mask_r <= 1'h0;
    end
    else
    begin
      oe_mask_r <= oe_mask_nxt;
    end
  end

  // output enable low drives, high releases for write data
  // output enable and sleep reach the drive with no flop
  assign o_data_io_oe = !i_output_enable_n && !i_sleep_request && !oe_mask_r &&
                        (state_r == fts_pkg::FTS_ACTIVE);

endmodule

/* File: dv/fts_sram_assertions.sv */
module fts_sram_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_byte_write_enable_n,
  input wire logic i_global_write_n,
  input wire logic i_chip_select_one_n,
  input wire logic i_chip_select_two,
  input wire logic i_chip_select_three_n,
  input wire logic i_output_enable_n,
  input wire logic i_sleep_request,
  input wire logic [2*fts_pkg::BYTE_W-1:0] i_data_io,
  input wire logic [2*fts_pkg::BYTE_W-1:0] o_data_io,
  input wire logic o_data_io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // port decode
  // ------------------------------------------------------------
  logic sel_ok, quiet, ctrl_ld, ld, rd_ld, hold, active_r;
  assign sel_ok = !i_chip_select_one_n && i_chip_select_two && !i_chip_select_three_n;
  assign quiet = i_processor_addr_strobe_n && i_controller_addr_strobe_n;
  assign ctrl_ld = !i_controller_addr_strobe_n && i_processor_addr_strobe_n;
  assign ld = (!i_processor_addr_strobe_n && !i_chip_select_one_n) || !i_controller_addr_strobe_n;
  assign hold = i_burst_advance_n && i_global_write_n && i_byte_write_enable_n;
  assign rd_ld = ctrl_ld && sel_ok && i_global_write_n && i_byte_write_enable_n;
  // select state mirror, so write checks know the device is live
  always_ff @(posedge i_sys_clk or negedge i_resetn)
    if (!i_resetn)
      active_r <= 1'h0;
    else if (ld)
      active_r <= sel_ok;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_drive_gated: assert property (o_data_io_oe |-> !i_output_enable_n && !i_sleep_request)
    else $error("drive without output enable");
  a_desel_quiet: assert property (ctrl_ld && !sel_ok |=> !o_data_io_oe)
    else $error("drive after deselect");
  a_first_mask: assert property (ctrl_ld && !sel_ok ##1 rd_ld |=> !o_data_io_oe)
    else $error("first read not masked");
  a_drive_after: assert property (rd_ld ##1 (quiet && hold)
    |=> o_data_io_oe == (!i_output_enable_n && !i_sleep_request))
    else $error("second beat not driven");
  a_proc_ignored: assert property (o_data_io_oe && !i_processor_addr_strobe_n
    && i_chip_select_one_n && i_controller_addr_strobe_n && hold |=> $stable(o_data_io))
    else $error("processor strobe taken");
  a_sel_ignored: assert property (o_data_io_oe && quiet && !i_chip_select_two
    |=> o_data_io_oe || i_output_enable_n || i_sleep_request)
    else $error("selects sampled mid burst");
  a_gw_write: assert property (active_r && quiet && i_burst_advance_n && !i_global_write_n
    && !i_sleep_request |=> o_data_io == $past(i_data_io))
    else $error("global write lost");
  a_sleep_hold: assert property (active_r && quiet && i_burst_advance_n && !i_global_write_n
    && i_sleep_request |=> $stable(o_data_io))
    else $error("write during sleep");
endmodule

bind fts_sram fts_sram_checker u_chk (.*);

/* File: dv/fts_host_model.sv */
module fts_host_model (
  input wire logic i_sys_clk,
  input wire logic [17:0] i_dev_d,
  input wire logic i_dev_oe,
  output logic [8:0] o_ctl,
  output logic [2:0] o_sel,
  output logic [17:0] o_addr,
  output logic [17:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // processor side of the burst bus
  // ------------------------------------------------------------
  logic [17:0] wr_r = 18'h00000;
  logic [17:0] last_r = 18'h00000;
  initial
  begin
    o_ctl = 9'h0FF;
    o_sel = 3'h0;
    o_addr = 18'h00000;
  end
  // host drives only with output enable high
  // released pins toggle so a stale value never reads as good
  always_comb
    o_bus = i_dev_oe ? i_dev_d : (o_ctl[0] ? wr_r : ~last_r);
  always_ff @(posedge i_sys_clk)
    last_r <= o_bus;
  // one cycle off the falling edge, held over the rise
  task automatic cyc(input logic [8:0] c, input logic [2:0] s, input logic [17:0] a,
                     input logic [17:0] d);
    @(negedge i_sys_clk);
    o_ctl = c;
    o_sel = s;
    o_addr = a;
    wr_r = d;
  endtask
endmodule

/* File: dv/fts_sram_tb.sv */
module fts_sram_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // control bits: sleep, proc, ctrl, adv, gw, bwe, lane1, lane0, oe
  // ------------------------------------------------------------
  localparam logic [8:0] IDL = 9'h0FF, Z = 9'h100, P = 9'h080, C = 9'h040, V = 9'h020;
  localparam logic [8:0] G = 9'h010, E = 9'h008, B1 = 9'h004, B0 = 9'h002, O = 9'h001;
  localparam logic [2:0] SEL = 3'h2, DES = 3'h0;
  localparam logic [17:0] LA = 18'h100FF, LB = 18'h2FF00, A = 18'h00100;
  logic i_sys_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic strap = 1'h1;
  logic [8:0] ctl;
  logic [2:0] sel;
  logic [17:0] addr, bus, rd;
  logic [15:0] dq;
  logic [1:0] parity_io;
  logic oe;
  logic [17:0] mem [int];
  int error_cnt = 0;
  int cmp_count = 0;
  assign rd = {parity_io, dq};
  always #5 i_sys_clk = ~i_sys_clk;
  fts_host_model host (.i_sys_clk(i_sys_clk), .i_dev_d(rd), .i_dev_oe(oe), .o_ctl(ctl),
    .o_sel(sel), .o_addr(addr), .o_bus(bus));
  fts_sram dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(addr),
    .i_processor_addr_strobe_n(ctl[7]), .i_controller_addr_strobe_n(ctl[6]),
    .i_burst_advance_n(ctl[5]), .i_global_write_n(ctl[4]), .i_byte_write_enable_n(ctl[3]),
    .i_byte_write_select_lane1_n(ctl[2]), .i_byte_write_select_lane0_n(ctl[1]),
    .i_output_enable_n(ctl[0]), .i_sleep_request(ctl[8]), .i_chip_select_one_n(sel[2]),
    .i_chip_select_two(sel[1]), .i_chip_select_three_n(sel[0]), .i_burst_order_strap(strap),
    .i_data_io(bus[15:0]), .i_parity_io(bus[17:16]), .o_data_io(dq), .o_parity_io(parity_io),
    .o_data_io_oe(oe));
  task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one cycle, then look just after the rising edge
  task automatic step(input logic [8:0] c, input logic [2:0] s, input logic [17:0] a,
                      input logic [17:0] d);
    host.cyc(c, s, a, d);
    @(posedge i_sys_clk);
    #1;
  endtask
  // strap only moves under reset; three idles let it settle
  task automatic rst(input logic m);
    // a mid-run reset is also applied on the falling edge
    if (i_resetn)
      @(negedge i_sys_clk);
    i_resetn = 1'h0;
    strap = m;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_resetn = 1'h1;
    repeat (3) step(IDL, DES, 18'h00000, 18'h00000);
  endtask
  function automatic logic [17:0] bt(input logic [17:0] a, input int i, input logic il);
    logic [1:0] k;
    k = 2'(i);
    return {a[17:2], il ? a[1:0] ^ k : a[1:0] + k};
  endfunction
  task automatic t_burst(input logic il);
    int j;
    rst(il);
    for (int i = 0; i < 4; i++)
    begin
      mem[bt(18'h12345, i, il)] = 18'h2A5A0 ^ 18'(i * 7 + il);
      step(i == 0 ? IDL ^ (C | G) : IDL ^ (V | G), SEL, 18'h12345, mem[bt(18'h12345, i, il)]);
    end
    step(IDL ^ C, DES, 18'h12345, 18'h00000);
    // beat 4 is a stall, beat 5 wraps to the start
    // read starts on another offset, so a wrong write order cannot hide
    for (int i = 0; i < 6; i++)
    begin
      j = i < 4 ? i : (i == 4 ? 3 : 0);
      step(i == 0 ? IDL ^ (C | O) : (i == 4 ? IDL ^ O : IDL ^ (V | O)), SEL, 18'h12347, 18'h0);
      chk("drive", {17'h00000, oe}, {17'h00000, i != 0});
      chk("beat", rd, mem[bt(18'h12347, j, il)]);
    end
  endtask
  task automatic t_lanes;
    logic [17:0] m;
    logic [8:0] c;
    for (int k = 0; k < 5; k++)
    begin
      m = k == 4 ? 18'h00000 : ((k[0] ? LA : 18'h00000) | (k[1] ? LB : 18'h00000));
      c = k == 4 ? IDL ^ (B1 | B0) : IDL ^ E ^ (k[0] ? B0 : 9'h000) ^ (k[1] ? B1 : 9'h000);
      step(IDL ^ (C | G), SEL, A, 18'h3FFFF);
      // byte enable paired with the lane selects; k == 4 drives both selects without it, so no lane writes
      step(c, SEL, A, 18'h15555);
      step(IDL ^ (C | O), SEL, A, 18'h00000);
      chk("lanes", rd, (18'h3FFFF & ~m) | (18'h15555 & m));
    end
    mem[A] = 18'h3FFFF;
  endtask
  task automatic t_select;
    for (int k = 0; k < 8; k++)
    begin
      step(IDL ^ C, DES, A, 18'h00000);
      // deselected loads offer a foreign address that must not be taken
      step(IDL ^ (C | O), 3'(k), k == 2 ? A : 18'h12345, 18'h00000);
      step(IDL ^ O, DES, A, 18'h00000);
      chk("select", {17'h00000, oe}, {17'h00000, k == 2});
      chk("desel_addr", rd, mem[A]);
    end
    step(IDL ^ (C | O), SEL, A, 18'h00000);
    step(IDL ^ O, SEL, A, 18'h00000);
    step(IDL ^ (P | O), 3'h6, 18'h12345, 18'h00000);
    chk("proc", rd, mem[A]);
    chk("proc_oe", {17'h00000, oe}, 18'h00001);
    step(IDL ^ (P | C | G), SEL, A, 18'h00000);
    step(IDL ^ (C | O), SEL, A, 18'h00000);
    chk("both", rd, mem[A]);
    step(IDL ^ (V | O), DES, A, 18'h00000);
    chk("advance", {17'h00000, oe}, 18'h00001);
  endtask
  task automatic t_sleep;
    host.cyc(IDL, SEL, A, 18'h00000);
    #1;
    chk("oe_async", {17'h00000, oe}, 18'h00000);
    @(posedge i_sys_clk);
    #1;
    step(IDL ^ G, SEL, A, 18'h0C3C3);
    step(IDL ^ O ^ Z, SEL, A, 18'h00000);
    chk("sleep_oe", {17'h00000, oe}, 18'h00000);
    step(IDL ^ G ^ Z, SEL, A, 18'h3FFFF);
    step(IDL ^ O, SEL, A, 18'h00000);
    chk("sleep_keep", rd, 18'h0C3C3);
    chk("wake_oe", {17'h00000, oe}, 18'h00001);
  endtask
  initial
  begin
    t_burst(1'h1);
    t_burst(1'h0);
    t_lanes;
    t_select;
    t_sleep;
    tally_and_finish;
  end
  // watchdog, far beyond the fewer than one hundred cycles the tests need
  initial
  begin
    #20000;
    error_cnt++;
    tally_and_finish;
  end
endmodule
